// *** rtl/adc_regs.svh ***
// adc_regs.svh: command codes, field positions and reset values of the
// three configuration registers.
// assumes: included by the package and the decode and register design files by its bare name.
`ifndef ADC_REGS_SVH
`define ADC_REGS_SVH

// command codes, write and read forms
`define ADC_WR_RATE      8'hc0
`define ADC_WR_DELAY     8'hc1
`define ADC_WR_MEM       8'hc2
`define ADC_RD_RATE      8'h40
`define ADC_RD_DELAY     8'h41
`define ADC_RD_MEM       8'h42

// reset values
`define ADC_RST_RATE     8'h00
`define ADC_RST_DELAY    8'h00
`define ADC_RST_MEM      8'h00

// writable field masks; d0 always zero, test bit d3 of delay register kept zero
`define ADC_MASK_RATE    8'hfe
`define ADC_MASK_DELAY   8'hf6
`define ADC_MASK_MEM     8'hfe

// field positions
`define ADC_B_PCM_SEL    7
`define ADC_B_I2S_SEL    6
`define ADC_B_PCM_HI     5
`define ADC_B_PCM_LO     4
`define ADC_B_RATE_HI    3
`define ADC_B_RATE_LO    1
`define ADC_B_MUTE_T     7
`define ADC_B_VOL_T      6
`define ADC_B_PART_HI    5
`define ADC_B_PART_LO    4
`define ADC_B_STEP_HI    2
`define ADC_B_STEP_LO    1
`define ADC_B_PTR_SRC    7
`define ADC_B_WORK_ADR   6
`define ADC_B_SHORT_BCK  5
`define ADC_B_WAVE_M     4
`define ADC_B_WAVP_HI    3
`define ADC_B_WAVP_LO    2
`define ADC_B_EXT_INS    1

// derived figures
`define ADC_MUTE_FRAMES  912
`define ADC_MUTE_LONG_X  4
`define ADC_VOL_LONG_FS  4
`define ADC_RING24_M0    3072
`define ADC_RING24_M1    2048
`define ADC_RING84_M1    2048
`define ADC_RING24_M2    1024
`define ADC_RING84_M2    2048
`define ADC_LIN24_M2     1024
`define ADC_AREA_B_BASE  11'h400
`define ADC_AREA_B_END   11'h5ff
`define ADC_AREA_A_END   11'h3ff
`define ADC_BCK_64       7'h40
`define ADC_BCK_32       7'h20
`define ADC_CKM_FIRST_BCK 3'h3
`define ADC_CKM_SHORT_BCK 3'h4
`define ADC_CKM_LAST_BCK  3'h5
`define ADC_B_TEST_BIT   3

`endif

// *** rtl/adc_pkg.sv ***
// adc_pkg.sv: types shared by the configuration register bank.
// assumes: adc_regs.svh is on the include path.
`include "adc_regs.svh"

package adc_pkg;

	// decoded framing selection
	typedef enum logic [1:0] {
		ADC_FMT_JUSTIFIED,
		ADC_FMT_I2S,
		ADC_FMT_PCM
	} adc_fmt_t;

	// decoded sample rate
	typedef enum logic [2:0] {
		ADC_FS_48,
		ADC_FS_32,
		ADC_FS_16,
		ADC_FS_8,
		ADC_FS_96,
		ADC_FS_BAD
	} adc_fs_t;

	// serial port configuration
	typedef struct packed {
		adc_fmt_t   fmt;
		logic       pcm_long_frame;
		logic       pcm_falling_edge;
		adc_fs_t    fs;
		logic [6:0] bck_per_frame;
	} adc_port_cfg_t;

	// memory configuration
	typedef struct packed {
		logic [11:0] ring24_words;
		logic [11:0] ring84_words;
		logic [11:0] lin24_words;
		logic        part_applies_84;
		logic [3:0]  step_period;
		logic        ptr_from_bus;
		logic        area_b_linear;
		logic        wave_half;
		logic [1:0]  wave_points;
		logic        ext_instr;
	} adc_mem_cfg_t;

	// ramp configuration
	typedef struct packed {
		logic [11:0] mute_frames;
		logic [2:0]  vol_step_fs;
	} adc_ramp_cfg_t;

endpackage : adc_pkg

// *** rtl/adc_cmd_port.sv ***
// adc_cmd_port.sv: command port front end; resynchronises the host's write
// and read strobes and presents one-cycle requests to the register bank.
// assumes: strobes are levels from the host, held at least three clocks.
`timescale 1ns/100ps

module adc_cmd_port
	import adc_pkg::*;
(
	// clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_rst_b,
	input  wire logic       i_ce,
	// host side, asynchronous
	input  wire logic       i_wr_req,
	input  wire logic       i_rd_req,
	input  wire logic [7:0] i_cmd,
	input  wire logic [7:0] i_wdata,
	// bank side
	output logic            o_wr_pulse,
	output logic            o_rd_pulse,
	output logic [7:0]      o_cmd,
	output logic [7:0]      o_wdata
);

	//////////////////////////////////////////////////////////////////////
	// two-stage synchronisers plus one edge stage
	logic [2:0] wr_sync_ff, nxt_wr_sync;
	logic [2:0] rd_sync_ff, nxt_rd_sync;
	logic [7:0] cmd_s1_ff, cmd_s2_ff, nxt_cmd_s1, nxt_cmd_s2;
	logic [7:0] dat_s1_ff, dat_s2_ff, nxt_dat_s1, nxt_dat_s2;

	// next values; data is stable before the strobe so no gray coding needed
	always_comb begin
		nxt_wr_sync = i_ce ? {wr_sync_ff[1:0], i_wr_req} : wr_sync_ff;
		nxt_rd_sync = i_ce ? {rd_sync_ff[1:0], i_rd_req} : rd_sync_ff;
		nxt_cmd_s1  = i_ce ? i_cmd : cmd_s1_ff;
		nxt_cmd_s2  = i_ce ? cmd_s1_ff : cmd_s2_ff;
		nxt_dat_s1  = i_ce ? i_wdata : dat_s1_ff;
		nxt_dat_s2  = i_ce ? dat_s1_ff : dat_s2_ff;
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			wr_sync_ff <= 3'h0;
			rd_sync_ff <= 3'h0;
			cmd_s1_ff  <= 8'h00;
			cmd_s2_ff  <= 8'h00;
			dat_s1_ff  <= 8'h00;
			dat_s2_ff  <= 8'h00;
		end else begin
			wr_sync_ff <= nxt_wr_sync;
			rd_sync_ff <= nxt_rd_sync;
			cmd_s1_ff  <= nxt_cmd_s1;
			cmd_s2_ff  <= nxt_cmd_s2;
			dat_s1_ff  <= nxt_dat_s1;
			dat_s2_ff  <= nxt_dat_s2;
		end
	end

	// rising edges seen only on synchronised stages
	assign o_wr_pulse = i_ce & wr_sync_ff[1] & ~wr_sync_ff[2];
	assign o_rd_pulse = i_ce & rd_sync_ff[1] & ~rd_sync_ff[2];
	assign o_cmd      = cmd_s2_ff;
	assign o_wdata    = dat_s2_ff;

endmodule : adc_cmd_port

// *** rtl/adc_cfg_decode.sv ***
// adc_cfg_decode.sv: turns the raw register values into structured settings
// for the serial port, ramps and memory addressing.
// assumes: inputs come from registers on the same clock.
`timescale 1ns/100ps
`include "adc_regs.svh"

module adc_cfg_decode
	import adc_pkg::*;
(
	// raw register values and pins
	input  wire logic [7:0]  i_rate,
	input  wire logic [7:0]  i_delay,
	input  wire logic [7:0]  i_mem,
	input  wire logic [2:0]  i_ckm,
	// decoded settings
	output adc_port_cfg_t    o_port,
	output adc_mem_cfg_t     o_mem,
	output adc_ramp_cfg_t    o_ramp
);

	// rate code to fs; pins fix the rate in bit-clock slave modes
	function automatic adc_fs_t rate_dec(input logic [2:0] code, input logic [2:0] ckm);
		adc_fs_t f;
		f = ADC_FS_BAD;
		if (ckm == `ADC_CKM_FIRST_BCK) begin
			f = ADC_FS_48;
		end else if (ckm > `ADC_CKM_LAST_BCK) begin
			f = ADC_FS_BAD; // modes 6 and 7 have no usable rate
		end else if (ckm > `ADC_CKM_FIRST_BCK) begin
			f = ADC_FS_8;
		end else begin
			case (code)
				3'h0: f = ADC_FS_48;
				3'h1: f = ADC_FS_32;
				3'h2: f = ADC_FS_16;
				3'h3: f = ADC_FS_8;
				3'h4: f = ADC_FS_96;
				default: f = ADC_FS_BAD;
			endcase
		end
		return f;
	endfunction : rate_dec

	//////////////////////////////////////////////////////////////////////
	// serial port framing
	always_comb begin
		o_port = '0;
		if (i_rate[`ADC_B_PCM_SEL]) begin
			o_port.fmt              = ADC_FMT_PCM;
			o_port.pcm_long_frame   = i_rate[`ADC_B_PCM_HI];
			o_port.pcm_falling_edge = i_rate[`ADC_B_PCM_LO];
		end else if (i_rate[`ADC_B_I2S_SEL]) begin
			o_port.fmt = ADC_FMT_I2S;
		end else begin
			o_port.fmt = ADC_FMT_JUSTIFIED;
		end
		o_port.fs = rate_dec(i_rate[`ADC_B_RATE_HI:`ADC_B_RATE_LO], i_ckm);
		o_port.bck_per_frame = i_mem[`ADC_B_SHORT_BCK] ? `ADC_BCK_32 : `ADC_BCK_64;
	end

	// ramp timing
	always_comb begin
		o_ramp.mute_frames = i_delay[`ADC_B_MUTE_T] ?
			12'(`ADC_MUTE_FRAMES * `ADC_MUTE_LONG_X) : 12'(`ADC_MUTE_FRAMES);
		o_ramp.vol_step_fs = i_delay[`ADC_B_VOL_T] ? 3'(`ADC_VOL_LONG_FS) : 3'h1;
	end

	// delay and work memory
	always_comb begin
		o_mem = '0;
		case (i_delay[`ADC_B_PART_HI:`ADC_B_PART_LO])
			2'h0: o_mem.ring24_words = 12'(`ADC_RING24_M0);
			2'h1: begin
				o_mem.ring24_words = 12'(`ADC_RING24_M1);
				o_mem.ring84_words = 12'(`ADC_RING84_M1);
			end
			2'h2: begin
				o_mem.ring24_words = 12'(`ADC_RING24_M2);
				o_mem.ring84_words = 12'(`ADC_RING84_M2);
				o_mem.lin24_words  = 12'(`ADC_LIN24_M2);
			end
			default: o_mem.ring24_words = 12'(`ADC_RING24_M0);
		endcase
		o_mem.part_applies_84 = (i_delay[`ADC_B_PART_HI:`ADC_B_PART_LO] != 2'h0);
		o_mem.step_period   = 4'(4'h1 << i_delay[`ADC_B_STEP_HI:`ADC_B_STEP_LO]);
		o_mem.ptr_from_bus  = i_mem[`ADC_B_PTR_SRC];
		o_mem.area_b_linear = i_mem[`ADC_B_WORK_ADR];
		o_mem.wave_half     = i_mem[`ADC_B_WAVE_M];
		o_mem.wave_points   = i_mem[`ADC_B_WAVP_HI:`ADC_B_WAVP_LO];
		o_mem.ext_instr     = i_mem[`ADC_B_EXT_INS];
	end

endmodule : adc_cfg_decode

// *** rtl/adc_cfg_regs.sv ***
// adc_cfg_regs.sv: rate/format, delay-memory and memory-mode control
// registers, with a delay-memory address stepper and work-memory address
// wrap logic driven from them.
// assumes: host strobes are asynchronous levels; clock mode pins are static.
`timescale 1ns/100ps
`include "adc_regs.svh"

module adc_cfg_regs
	import adc_pkg::*;
#(
	parameter int WORK_ADDR_W = 11
) (
	// clock, enable and initial reset
	input  wire logic                   i_clk,
	input  wire logic                   i_rst_b,
	input  wire logic                   i_ce,
	// host command port
	input  wire logic                   i_wr_req,
	input  wire logic                   i_rd_req,
	input  wire logic [7:0]             i_cmd,
	input  wire logic [7:0]             i_wdata,
	output logic [7:0]                  o_rdata,
	output logic                        o_rd_valid,
	// device pins and processor events
	input  wire logic [2:0]             i_clock_mode_pins,
	input  wire logic                   i_sample_tick,
	input  wire logic                   i_work_step,
	input  wire logic                   i_work_area_b,
	// decoded configuration
	output adc_port_cfg_t               o_port_cfg,
	output adc_mem_cfg_t                o_mem_cfg,
	output adc_ramp_cfg_t               o_ramp_cfg,
	output logic                        o_delay_addr_step,
	output logic [WORK_ADDR_W-1:0]      o_work_addr
);

	//////////////////////////////////////////////////////////////////////
	// elaboration check
	initial begin
		if (WORK_ADDR_W != 11) begin
			$error("work address must be 11 bits wide to hold areas a and b");
		end
	end

	// masks a written byte to its defined fields
	function automatic logic [7:0] field_mask(input logic [7:0] v, input logic [7:0] m);
		return v & m;
	endfunction : field_mask

	//////////////////////////////////////////////////////////////////////
	// command front end and pin synchronisers
	logic       wr_pulse, rd_pulse;
	logic [7:0] cmd, wdata;
	logic [2:0] ckm_s1_ff, ckm_s2_ff, nxt_ckm_s1, nxt_ckm_s2;
	logic [1:0] tick_sync_ff, nxt_tick_sync;
	logic       tick_d_ff, nxt_tick_d;

	adc_cmd_port u_cmd (
		.i_clk      (i_clk),
		.i_rst_b    (i_rst_b),
		.i_ce       (i_ce),
		.i_wr_req   (i_wr_req),
		.i_rd_req   (i_rd_req),
		.i_cmd      (i_cmd),
		.i_wdata    (i_wdata),
		.o_wr_pulse (wr_pulse),
		.o_rd_pulse (rd_pulse),
		.o_cmd      (cmd),
		.o_wdata    (wdata)
	);

	// pins and the sample tick come from outside this clock
	always_comb begin
		nxt_ckm_s1    = i_ce ? i_clock_mode_pins : ckm_s1_ff;
		nxt_ckm_s2    = i_ce ? ckm_s1_ff : ckm_s2_ff;
		nxt_tick_sync = i_ce ? {tick_sync_ff[0], i_sample_tick} : tick_sync_ff;
		nxt_tick_d    = i_ce ? tick_sync_ff[1] : tick_d_ff;
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ckm_s1_ff    <= 3'h0;
			ckm_s2_ff    <= 3'h0;
			tick_sync_ff <= 2'h0;
			tick_d_ff    <= 1'b0;
		end else begin
			ckm_s1_ff    <= nxt_ckm_s1;
			ckm_s2_ff    <= nxt_ckm_s2;
			tick_sync_ff <= nxt_tick_sync;
			tick_d_ff    <= nxt_tick_d;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// register bank
	logic [7:0] rate_ff, delay_ff, mem_ff;
	logic [7:0] nxt_rate, nxt_delay, nxt_mem;
	logic [7:0] rdata_ff, nxt_rdata;
	logic       rd_valid_ff, nxt_rd_valid;
	logic       commit;

	// a byte with d0 set is refused so half-formed values never land
	assign commit = wr_pulse & ~wdata[0];

	// next register values; only the initial reset pin clears them, there is
	// no system-reset input here on purpose
	always_comb begin
		nxt_rate  = rate_ff;
		nxt_delay = delay_ff;
		nxt_mem   = mem_ff;
		if (commit) begin
			if (cmd == `ADC_WR_RATE) begin
				nxt_rate = field_mask(wdata, `ADC_MASK_RATE);
			end else if (cmd == `ADC_WR_DELAY) begin
				nxt_delay = field_mask(wdata, `ADC_MASK_DELAY);
			end else if (cmd == `ADC_WR_MEM) begin
				nxt_mem = field_mask(wdata, `ADC_MASK_MEM);
			end
		end
	end

	// read path; unknown codes read zero
	always_comb begin
		nxt_rdata    = rdata_ff;
		nxt_rd_valid = rd_pulse;
		if (rd_pulse) begin
			if (cmd == `ADC_RD_RATE) begin
				nxt_rdata = rate_ff;
			end else if (cmd == `ADC_RD_DELAY) begin
				nxt_rdata = delay_ff;
			end else if (cmd == `ADC_RD_MEM) begin
				nxt_rdata = mem_ff;
			end else begin
				nxt_rdata = 8'h00;
			end
		end
		if (!i_ce) begin
			nxt_rd_valid = rd_valid_ff;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rate_ff     <= `ADC_RST_RATE;
			delay_ff    <= `ADC_RST_DELAY;
			mem_ff      <= `ADC_RST_MEM;
			rdata_ff    <= 8'h00;
			rd_valid_ff <= 1'b0;
		end else if (i_ce) begin
			rate_ff     <= nxt_rate;
			delay_ff    <= nxt_delay;
			mem_ff      <= nxt_mem;
			rdata_ff    <= nxt_rdata;
			rd_valid_ff <= nxt_rd_valid;
		end
	end

	assign o_rdata    = rdata_ff;
	assign o_rd_valid = rd_valid_ff;

	//////////////////////////////////////////////////////////////////////
	// decoded settings
	adc_cfg_decode u_dec (
		.i_rate  (rate_ff),
		.i_delay (delay_ff),
		.i_mem   (mem_ff),
		.i_ckm   (ckm_s2_ff),
		.o_port  (o_port_cfg),
		.o_mem   (o_mem_cfg),
		.o_ramp  (o_ramp_cfg)
	);

	//////////////////////////////////////////////////////////////////////
	// delay-memory address stepper: one step each 1, 2, 4 or 8 samples
	logic [2:0] samp_cnt_ff, nxt_samp_cnt;
	logic       step_ff, nxt_step;
	logic       tick;
	logic [2:0] step_last;

	assign tick      = tick_sync_ff[1] & ~tick_d_ff;
	assign step_last = 3'(o_mem_cfg.step_period - 4'h1);

	always_comb begin
		nxt_samp_cnt = samp_cnt_ff;
		nxt_step     = 1'b0;
		if (tick) begin
			if (samp_cnt_ff >= step_last) begin
				nxt_samp_cnt = 3'h0;
				nxt_step     = 1'b1;
			end else begin
				nxt_samp_cnt = samp_cnt_ff + 3'h1;
			end
		end
		if (!i_ce) begin
			nxt_step = step_ff;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			samp_cnt_ff <= 3'h0;
			step_ff     <= 1'b0;
		end else if (i_ce) begin
			samp_cnt_ff <= nxt_samp_cnt;
			step_ff     <= nxt_step;
		end
	end

	assign o_delay_addr_step = step_ff;

	//////////////////////////////////////////////////////////////////////
	// work-memory pointer: area a rings, area b rings or saturates linearly
	logic [WORK_ADDR_W-1:0] wptr_ff, nxt_wptr;

	always_comb begin
		nxt_wptr = wptr_ff;
		if (i_work_step) begin
			if (!i_work_area_b) begin
				nxt_wptr = (wptr_ff >= `ADC_AREA_A_END) ? '0 : wptr_ff + 1'b1;
			end else if (wptr_ff < `ADC_AREA_B_BASE) begin
				nxt_wptr = `ADC_AREA_B_BASE;
			end else if (wptr_ff >= `ADC_AREA_B_END) begin
				nxt_wptr = o_mem_cfg.area_b_linear ? `ADC_AREA_B_END
					: `ADC_AREA_B_BASE;
			end else begin
				nxt_wptr = wptr_ff + 1'b1;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			wptr_ff <= '0;
		end else if (i_ce) begin
			wptr_ff <= nxt_wptr;
		end
	end

	assign o_work_addr = wptr_ff;

	//////////////////////////////////////////////////////////////////////
	// checks
	a_d0_refused: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(i_ce && wr_pulse && wdata[0]) |=> $stable(rate_ff) && $stable(mem_ff))
		else $error("write with d0 set changed a register");
	a_read_zero_lsb: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		o_rd_valid |-> (o_rdata[0] == 1'b0))
		else $error("read data bit d0 not zero");
	a_rate_write: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(i_ce && commit && cmd == `ADC_WR_RATE) |=> rate_ff == $past(wdata))
		else $error("rate register did not take written value");
	a_test_bit_zero: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		delay_ff[`ADC_B_TEST_BIT] == 1'b0)
		else $error("delay test bit not zero");
	a_pcm_selects: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		rate_ff[`ADC_B_PCM_SEL] |-> o_port_cfg.fmt == ADC_FMT_PCM)
		else $error("pcm bit did not select pcm framing");
	a_pcm_field_gated: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		!rate_ff[`ADC_B_PCM_SEL] |-> !o_port_cfg.pcm_long_frame && !o_port_cfg.pcm_falling_edge)
		else $error("pcm framing field used while pcm off");
	a_pins_fix_rate: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(ckm_s2_ff == `ADC_CKM_SHORT_BCK) |-> o_port_cfg.fs == ADC_FS_8)
		else $error("clock mode pins did not fix rate");
	a_mute_time: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		delay_ff[`ADC_B_MUTE_T] |-> o_ramp_cfg.mute_frames == 12'd3648)
		else $error("long mute ramp length wrong");
	a_step_spacing: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(step_ff && delay_ff[`ADC_B_STEP_HI:`ADC_B_STEP_LO] == 2'h3 && i_ce) |=> !step_ff [*2])
		else $error("delay address stepped too soon");
	a_area_a_ring: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(i_ce && i_work_step && !i_work_area_b && wptr_ff == `ADC_AREA_A_END)
		|=> wptr_ff == '0)
		else $error("area a pointer did not wrap");

endmodule : adc_cfg_regs

// *** bench/adc_host.sv ***
// adc_host.sv: host controller model driving the register command port.
// assumes: tasks are called just after a rising edge of i_clk.
`timescale 1ns/100ps

module adc_host (
	// clock
	input  wire logic       i_clk,
	// command port toward the bank
	output logic            o_wr_req,
	output logic            o_rd_req,
	output logic [7:0]      o_cmd,
	output logic [7:0]      o_wdata,
	// read answer
	input  wire logic       i_rd_valid,
	input  wire logic [7:0] i_rdata
);

	// strobes idle low from time zero
	initial begin
		o_wr_req = 1'b0;
		o_rd_req = 1'b0;
		o_cmd    = 8'h00;
		o_wdata  = 8'h00;
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic hold(input int n);
		repeat (n) @(posedge i_clk);
	endtask : hold

	// one write; the bench only issues legal values while the processor
	// counts as held in system reset, d0 zero except in the refusal case
	task automatic wr(input logic [7:0] cmd, input logic [7:0] dat);
		o_cmd   <= cmd;
		o_wdata <= dat;
		hold(4);
		o_wr_req <= 1'b1;
		hold(6);
		o_wr_req <= 1'b0;
		hold(4);
	endtask : wr

	// one read; strobe held until the answer is sampled, bounded wait
	task automatic rd(input logic [7:0] cmd, output logic [7:0] dat, output logic ok);
		ok  = 1'b0;
		dat = 8'h00;
		o_cmd <= cmd;
		hold(4);
		o_rd_req <= 1'b1;
		for (int i = 0; i < 10 && !ok; i++) begin
			@(posedge i_clk);
			if (i_rd_valid === 1'b1) begin
				ok  = 1'b1;
				dat = i_rdata;
			end
		end
		o_rd_req <= 1'b0;
		hold(4);
	endtask : rd

endmodule : adc_host

// *** bench/test_audio_dsp_config_regs_a.sv ***
// test_audio_dsp_config_regs_a.sv: self-checking bench of the config bank.
// assumes: rtl files and adc_host.sv compiled before this file.
`timescale 1ns/100ps

module test_audio_dsp_config_regs_a;
	import adc_pkg::*;

	// design signals
	logic          i_clk = 1'b0;
	logic          i_rst_b = 1'b0;
	logic          i_ce = 1'b1;
	logic          i_wr_req, i_rd_req, o_rd_valid, o_delay_addr_step;
	logic          i_sample_tick = 1'b0;
	logic          i_work_step = 1'b0;
	logic          i_work_area_b = 1'b0;
	logic [2:0]    i_clock_mode_pins = 3'h0;
	logic [7:0]    i_cmd, i_wdata, o_rdata;
	logic [10:0]   o_work_addr;
	adc_port_cfg_t o_port_cfg;
	adc_mem_cfg_t  o_mem_cfg;
	adc_ramp_cfg_t o_ramp_cfg;
	int            error_cnt = 0;
	int            n_compared = 0;
	int            n_steps = 0;
	logic [11:0]   r24 [3] = '{12'd3072, 12'd2048, 12'd1024};
	logic [11:0]   r84 [3] = '{12'd0, 12'd2048, 12'd2048};
	logic [11:0]   l24 [3] = '{12'd0, 12'd0, 12'd1024};

	// 200 mhz clock
	always #2.5 i_clk = ~i_clk;

	// count delay address advances
	always @(posedge i_clk) if (o_delay_addr_step === 1'b1) n_steps <= n_steps + 1;

	adc_cfg_regs #(.WORK_ADDR_W(11)) DUT (.i_clk, .i_rst_b, .i_ce, .i_wr_req, .i_rd_req,
		.i_cmd, .i_wdata, .o_rdata, .o_rd_valid, .i_clock_mode_pins, .i_sample_tick,
		.i_work_step, .i_work_area_b, .o_port_cfg, .o_mem_cfg, .o_ramp_cfg,
		.o_delay_addr_step, .o_work_addr);

	adc_host host (.i_clk, .o_wr_req(i_wr_req), .o_rd_req(i_rd_req), .o_cmd(i_cmd),
		.o_wdata(i_wdata), .i_rd_valid(o_rd_valid), .i_rdata(o_rdata));

	////////////////////////////////////////////////////////////////////////////
	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk);
	endtask : cyc

	task automatic give_verdict();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : give_verdict

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	// read through the host; a missing answer ends the run
	task automatic rchk(input logic [7:0] c, input logic [7:0] exp);
		logic [7:0] d;
		logic       ok;
		host.rd(c, d, ok);
		if (ok !== 1'b1) begin
			error_cnt++;
			$display("BAD %0t read answer missing", $time);
			give_verdict();
		end
		chk(d, exp, "read");
	endtask : rchk

	// sample ticks are held four clocks so the two-flop sync sees each edge
	task automatic tick(input int n);
		repeat (n) begin
			i_sample_tick <= 1'b1;
			cyc(4);
			i_sample_tick <= 1'b0;
			cyc(4);
		end
		cyc(8);
	endtask : tick

	task automatic wstep(input int n, input logic b);
		i_work_area_b <= b;
		i_work_step <= 1'b1;
		cyc(n);
		i_work_step <= 1'b0;
		cyc(2);
	endtask : wstep

	////////////////////////////////////////////////////////////////////////////
	task automatic t_rate();
		adc_fs_t e [5] = '{ADC_FS_48, ADC_FS_32, ADC_FS_16, ADC_FS_8, ADC_FS_96};
		for (int k = 0; k < 5; k++) begin
			host.wr(8'hc0, {4'h0, k[2:0], 1'b0});
			chk(o_port_cfg.fs, e[k], "rate");
			rchk(8'h40, {4'h0, k[2:0], 1'b0});
		end
	endtask : t_rate

	// pins 3 to 5 fix the rate whatever the field holds; pins 0 leave the field's code 100 in force
	task automatic t_pins();
		adc_fs_t    e [4] = '{ADC_FS_96, ADC_FS_48, ADC_FS_8, ADC_FS_8};
		logic [2:0] p [4] = '{3'h0, 3'h3, 3'h4, 3'h5};
		for (int i = 0; i < 4; i++) begin
			i_clock_mode_pins <= p[i];
			cyc(5);
			chk(o_port_cfg.fs, e[i], "pins");
		end
		i_clock_mode_pins <= 3'h3;
		cyc(5);
	endtask : t_pins

	task automatic t_frame();
		for (int k = 0; k < 4; k++) begin
			host.wr(8'hc0, {2'b10, k[1:0], 4'h0});
			chk(o_port_cfg.fmt, ADC_FMT_PCM, "pcm");
			chk(o_port_cfg.pcm_long_frame, k[1], "long");
			chk(o_port_cfg.pcm_falling_edge, k[0], "edge");
		end
		host.wr(8'hc0, 8'h70);
		chk(o_port_cfg.fmt, ADC_FMT_I2S, "i2s");
		chk({o_port_cfg.pcm_long_frame, o_port_cfg.pcm_falling_edge}, 2'b00, "gate");
		host.wr(8'hc0, 8'h30);
		chk(o_port_cfg.fmt, ADC_FMT_JUSTIFIED, "just");
	endtask : t_frame

	task automatic t_refuse();
		host.wr(8'hc0, 8'h88);
		host.wr(8'hc0, 8'h43);
		rchk(8'h40, 8'h88);
		host.wr(8'hc6, 8'h20);
		rchk(8'h46, 8'h00);
	endtask : t_refuse

	task automatic t_delay();
		logic [7:0] v;
		int         s;
		for (int k = 0; k < 4; k++) begin
			v = {k[0], k[1], (k == 3) ? 2'h0 : k[1:0], 1'b1, k[1:0], 1'b0};
			host.wr(8'hc1, v);
			chk(o_ramp_cfg.mute_frames, k[0] ? 12'd3648 : 12'd912, "mute");
			chk(o_ramp_cfg.vol_step_fs, k[1] ? 3'h4 : 3'h1, "vol");
			chk(o_mem_cfg.ring24_words, r24[v[5:4]], "r24");
			chk(o_mem_cfg.ring84_words, r84[v[5:4]], "r84");
			chk(o_mem_cfg.lin24_words, l24[v[5:4]], "lin");
			chk(o_mem_cfg.part_applies_84, v[5:4] != 2'h0, "p84");
			chk(o_mem_cfg.step_period, 4'h1 << k, "per");
			rchk(8'h41, v & 8'hf6);
			s = n_steps;
			tick(8);
			chk(n_steps - s, 8 >> k, "steps");
		end
	endtask : t_delay

	task automatic t_mem();
		i_clock_mode_pins <= 3'h4;
		host.wr(8'hc2, 8'he0);
		chk(o_mem_cfg.ptr_from_bus, 1'b1, "ptr");
		chk(o_mem_cfg.area_b_linear, 1'b1, "lin");
		chk(o_port_cfg.bck_per_frame, 7'h20, "bck");
		chk(o_mem_cfg.wave_half, 1'b0, "wave");
		rchk(8'h42, 8'he0);
		// long bit clock is only legal outside clock mode 4
		i_clock_mode_pins <= 3'h3;
		host.wr(8'hc2, 8'h1e);
		chk({o_mem_cfg.wave_half, o_mem_cfg.ptr_from_bus, o_mem_cfg.wave_points,
			o_mem_cfg.ext_instr}, 5'b10111, "wave");
		chk(o_port_cfg.bck_per_frame, 7'h40, "bck");
		rchk(8'h42, 8'h1e);
	endtask : t_mem

	// area a rings even with area b set linear
	task automatic t_work();
		host.wr(8'hc2, 8'h40);
		wstep(1023, 1'b0);
		chk(o_work_addr, 11'h3ff, "a end");
		wstep(1, 1'b0);
		chk(o_work_addr, 11'h000, "a wrap");
		wstep(512, 1'b1);
		chk(o_work_addr, 11'h5ff, "b end");
		wstep(1, 1'b1);
		chk(o_work_addr, 11'h5ff, "b hold");
		host.wr(8'hc2, 8'h00);
		wstep(1, 1'b1);
		chk(o_work_addr, 11'h400, "b ring");
		// a low clock enable must freeze the pointer
		i_ce <= 1'b0;
		wstep(5, 1'b1);
		chk(o_work_addr, 11'h400, "frozen");
		i_ce <= 1'b1;
	endtask : t_work

	task automatic t_reinit();
		host.wr(8'hc1, 8'hc2);
		rchk(8'h41, 8'hc2);
		i_rst_b <= 1'b0;
		cyc(3);
		i_rst_b <= 1'b1;
		cyc(2);
		rchk(8'h41, 8'h00);
		chk(o_work_addr, 11'h000, "addr");
	endtask : t_reinit

	////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		cyc(12);
		i_rst_b <= 1'b1;
		cyc(2);
		chk(o_port_cfg.fmt, ADC_FMT_JUSTIFIED, "fmt");
		chk(o_port_cfg.bck_per_frame, 7'h40, "bck");
		chk(o_ramp_cfg.mute_frames, 12'd912, "mute");
		rchk(8'h40, 8'h00);
		rchk(8'h42, 8'h00);
		t_rate();
		t_pins();
		t_frame();
		t_refuse();
		t_delay();
		t_mem();
		t_work();
		t_reinit();
		give_verdict();
	end

endmodule : test_audio_dsp_config_regs_a
